/* File: pkg/txhw_consts.svh */
// Purpose: register offsets, field positions and reset values of the
//          transmit and hardware configuration registers
// Assumes: byte offsets on the host register port
// Notes:   definitions only
`ifndef TXHW_CONSTS_SVH
`define TXHW_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define TXHW_OFF_TX_CFG 8'h70
`define TXHW_OFF_HARDWARE_CONFIGURATION 8'h74
// ----------------------------------------
// transmit configuration fields
// ----------------------------------------
`define TXHW_TX_STS_FLUSH_BIT 15
`define TXHW_TX_DAT_FLUSH_BIT 14
`define TXHW_TX_OVR_BIT 2
`define TXHW_TX_ON_BIT 1
`define TXHW_TX_STOP_BIT 0
// ----------------------------------------
// hardware configuration fields
// ----------------------------------------
`define TXHW_HW_STRAP_BIT 24
`define TXHW_HW_MBO_BIT 20
`define TXHW_HW_SZ_HI 19
`define TXHW_HW_SZ_LO 16
`define TXHW_HW_CLK_HI 6
`define TXHW_HW_CLK_LO 5
`define TXHW_SZ_RESET 4'h5
`define TXHW_SZ_MAX 4'he
`define TXHW_CLK_RESET 2'h0
// ----------------------------------------
// receive end alignment, bytes
// ----------------------------------------
`define TXHW_ALIGN_B4 6'h04
`define TXHW_ALIGN_B16 6'h10
`define TXHW_ALIGN_B32 6'h20
// ----------------------------------------
// fifo arithmetic, bytes
// ----------------------------------------
`define TXHW_KB_SHIFT 10
`define TXHW_TX_STS_BYTES 15'h0200
`define TXHW_TOTAL_BYTES 15'h4000
`define TXHW_ZERO32 32'h0000_0000
`endif

/* File: pkg/txhw_pkg.sv */
// Purpose: shared types of the transmit and hardware configuration block
// Assumes: nothing
// Notes:   numbers live in txhw_consts.svh
`default_nettype none
package txhw_pkg;
   // receive end alignment codes
   typedef enum logic [1:0] {
      TXHW_ALIGN_4 = 2'b00,
      TXHW_ALIGN_16 = 2'b01,
      TXHW_ALIGN_32 = 2'b10,
      TXHW_ALIGN_RSVD = 2'b11
   } txhw_align_e;
   // media clock source codes
   typedef enum logic [1:0] {
      TXHW_CLK_INT = 2'b00,
      TXHW_CLK_EXT = 2'b01,
      TXHW_CLK_OFF = 2'b10,
      TXHW_CLK_INT2 = 2'b11
   } txhw_clk_e;
   // host register access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } txhw_req_s;
   // fifo partition in bytes
   typedef struct packed {
      logic [14:0] tx_total;
      logic [14:0] tx_status;
      logic [14:0] tx_data;
      logic [14:0] rx_total;
   } txhw_part_s;
endpackage
`default_nettype wire

/* File: rtl/txhw_part.sv */
// Purpose: splits the 16KB packet buffer between transmit and receive
// Assumes: allocation code already limited by the register
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "txhw_consts.svh"
module txhw_part
   import txhw_pkg::*;
(
   // allocation in 1KB units
   input wire logic [3:0] alloc_in,
   // resulting partition
   output txhw_part_s part_out
);
   logic [14:0] total;
   // ----------------------------------------
   // partition arithmetic
   // ----------------------------------------
   always_comb begin
      total = 15'({11'h000, alloc_in} << `TXHW_KB_SHIFT);
      part_out.tx_total = total;
      part_out.tx_status = `TXHW_TX_STS_BYTES;
      part_out.tx_data = total - `TXHW_TX_STS_BYTES;
      part_out.rx_total = `TXHW_TOTAL_BYTES - total;
   end
endmodule
`default_nettype wire

/* File: rtl/txhw_regs.sv */
// Purpose: transmit and hardware configuration registers with the
//          transmitter stop handshake and fifo flush strobes
// Assumes: synchronous host read/write strobes on clk_in, one cycle each
// Notes:   read data registered one cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
`include "txhw_consts.svh"
module txhw_regs
   import txhw_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // host register port
   input wire txhw_req_s req_in,
   output logic [31:0] rdata_out,
   // receive alignment code from the receive configuration register
   input wire logic [1:0] rx_align_code_in,
   // transmitter state
   input wire logic tx_frame_busy_in,
   input wire logic tx_status_full_in,
   // strap pin, asynchronous
   input wire logic auto_crossover_strap_in,
   // transmit controls
   output logic tx_run_out,
   output logic tx_on_out,
   output logic tx_status_flush_out,
   output logic tx_data_flush_out,
   output logic tx_status_full_irq_out,
   // hardware configuration and receive alignment
   output logic must_be_one_bit_out,
   output logic [3:0] tx_fifo_allocation_out,
   output logic [1:0] media_clock_source_out,
   output logic [1:0] media_clock_sel_out,
   output logic media_clock_off_out,
   output txhw_part_s partition_out,
   output logic [5:0] rx_align_bytes_out
);
   logic tx_on;                 // transmitter enable
   logic tx_stop;               // stop request pending
   logic tx_ovr;                // status overrun permission
   logic must_be_one_bit;                   // must-be-one bit
   logic [3:0] alloc;           // transmit allocation code
   logic [1:0] clk_src;         // media clock source code
   logic strap_meta;            // first synchroniser stage
   logic strap_sync;            // second synchroniser stage
   logic wr_tx;                 // write to transmit configuration
   logic wr_hw;                 // write to hardware configuration
   logic halted;                // transmitter idle after stop
   logic [3:0] next_alloc;      // limited allocation value
   txhw_part_s part;            // computed partition

   assign wr_tx = req_in.wr && (req_in.addr == `TXHW_OFF_TX_CFG);
   assign wr_hw = req_in.wr && (req_in.addr == `TXHW_OFF_HARDWARE_CONFIGURATION);
   // stop takes effect only between frames
   assign halted = tx_stop && !tx_frame_busy_in;

   // ----------------------------------------
   // transmit enable and stop handshake
   // ----------------------------------------
   // hardware clearing wins over a simultaneous write, so a stop that
   // completes in the same cycle as a write is never lost
   // a write that sets enable and stop together arms both in one cycle
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_on <= 1'b0;
         tx_stop <= 1'b0;
      end else begin
         if (halted) begin
            tx_on <= 1'b0;
         end else if (wr_tx) begin
            tx_on <= req_in.wdata[`TXHW_TX_ON_BIT];
         end
         if (halted) begin
            tx_stop <= 1'b0;
         end else if (wr_tx && !tx_stop) begin
            tx_stop <= req_in.wdata[`TXHW_TX_STOP_BIT];
         end
      end
   end

   // ----------------------------------------
   // overrun permission
   // ----------------------------------------
   // plain read/write bit; it only gates tx_run_out
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_ovr <= 1'b0;
      end else if (wr_tx) begin
         tx_ovr <= req_in.wdata[`TXHW_TX_OVR_BIT];
      end
   end

   // ----------------------------------------
   // transmitter run qualifier
   // ----------------------------------------
   // enable lets fifo drain
   // current frame finishes first
   // registered so the output is a clean flop; the cost is one cycle
   // of latency between a control change and the transmitter seeing it
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_run_out <= 1'b0;
      end else begin
         tx_run_out <= tx_on && (tx_ovr || !tx_status_full_in) &&
                       !(tx_stop && !tx_frame_busy_in);
      end
   end

   // ----------------------------------------
   // status full interrupt source
   // ----------------------------------------
   // independent of overrun bit
   // the overrun bit is deliberately absent here, so software sees a
   // full status fifo in either mode
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_status_full_irq_out <= 1'b0;
      end else begin
         tx_status_full_irq_out <= tx_status_full_in;
      end
   end

   // ----------------------------------------
   // self-clearing flush strobes
   // ----------------------------------------
   // the bits never hold a one, so they read back as zero
   // a write with both flush bits pulses both strobes in the same cycle
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_status_flush_out <= 1'b0;
         tx_data_flush_out <= 1'b0;
      end else begin
         tx_status_flush_out <= wr_tx && req_in.wdata[`TXHW_TX_STS_FLUSH_BIT];
         tx_data_flush_out <= wr_tx && req_in.wdata[`TXHW_TX_DAT_FLUSH_BIT];
      end
   end

   // ----------------------------------------
   // hardware configuration register
   // ----------------------------------------
   // values above 14KB are clamped; the host is trusted to stay at or
   // above 2KB and to stop tx/rx before writing (not checked here)
   always_comb begin
      next_alloc = req_in.wdata[`TXHW_HW_SZ_HI:`TXHW_HW_SZ_LO];
      if (next_alloc > `TXHW_SZ_MAX) begin
         next_alloc = `TXHW_SZ_MAX;
      end
   end

   // the must-be-one bit reads back and drives must_be_one_bit_out; nothing inside is gated by it
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         must_be_one_bit <= 1'b0;
         alloc <= `TXHW_SZ_RESET;
         clk_src <= `TXHW_CLK_RESET;
      end else if (wr_hw) begin
         must_be_one_bit <= req_in.wdata[`TXHW_HW_MBO_BIT];
         alloc <= next_alloc;
         clk_src <= req_in.wdata[`TXHW_HW_CLK_HI:`TXHW_HW_CLK_LO];
      end
   end

   // ----------------------------------------
   // crossover strap sampling
   // ----------------------------------------
   // strap synchronised then reported
   // only strap_sync is read anywhere; strap_meta may go metastable
   // limitation: a strap change shows two edges late in the read data
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         strap_meta <= 1'b0;
         strap_sync <= 1'b0;
      end else begin
         strap_meta <= auto_crossover_strap_in;
         strap_sync <= strap_meta;
      end
   end

   // ----------------------------------------
   // fifo partition
   // ----------------------------------------
   // the partition follows the stored code, never the raw write data,
   // so a clamped value can never yield a negative receive share
   txhw_part u_part (
      .alloc_in(alloc),
      .part_out(part)
   );

   // ----------------------------------------
   // registered configuration outputs
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_on_out <= 1'b0;
         must_be_one_bit_out <= 1'b0;
         tx_fifo_allocation_out <= `TXHW_SZ_RESET;
         media_clock_source_out <= `TXHW_CLK_RESET;
         media_clock_sel_out <= TXHW_CLK_INT;
         media_clock_off_out <= 1'b0;
         partition_out <= '0;
      end else begin
         tx_on_out <= tx_on;
         must_be_one_bit_out <= must_be_one_bit;
         tx_fifo_allocation_out <= alloc;
         media_clock_source_out <= clk_src;
         unique case (txhw_clk_e'(clk_src))
            TXHW_CLK_EXT: begin
               media_clock_sel_out <= TXHW_CLK_EXT;
               media_clock_off_out <= 1'b0;
            end
            TXHW_CLK_OFF: begin
               media_clock_sel_out <= TXHW_CLK_INT;
               media_clock_off_out <= 1'b1;
            end
            TXHW_CLK_INT, TXHW_CLK_INT2: begin
               media_clock_sel_out <= TXHW_CLK_INT;
               media_clock_off_out <= 1'b0;
            end
         endcase
         partition_out <= part;
      end
   end

   // ----------------------------------------
   // receive end alignment decode
   // ----------------------------------------
   // code from bits 31:30
   // alignment decode
   // the code is a level from logic on this clock, so no synchroniser;
   // it is registered only to keep the output a flop
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rx_align_bytes_out <= `TXHW_ALIGN_B4;
      end else begin
         unique case (txhw_align_e'(rx_align_code_in))
            TXHW_ALIGN_4: rx_align_bytes_out <= `TXHW_ALIGN_B4;
            TXHW_ALIGN_16: rx_align_bytes_out <= `TXHW_ALIGN_B16;
            TXHW_ALIGN_32: rx_align_bytes_out <= `TXHW_ALIGN_B32;
            // reserved code: fall back to plain word alignment
            TXHW_ALIGN_RSVD: rx_align_bytes_out <= `TXHW_ALIGN_B4;
         endcase
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   // reserved bits read zero
   // unmapped offsets read as zero; the data holds until the next read,
   // so a slow host may take it late
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_out <= `TXHW_ZERO32;
      end else if (req_in.rd) begin
         rdata_out <= `TXHW_ZERO32;
         if (req_in.addr == `TXHW_OFF_TX_CFG) begin
            rdata_out[`TXHW_TX_OVR_BIT] <= tx_ovr;
            rdata_out[`TXHW_TX_ON_BIT] <= tx_on;
            rdata_out[`TXHW_TX_STOP_BIT] <= tx_stop;
         end else if (req_in.addr == `TXHW_OFF_HARDWARE_CONFIGURATION) begin
            rdata_out[`TXHW_HW_STRAP_BIT] <= strap_sync;
            rdata_out[`TXHW_HW_MBO_BIT] <= must_be_one_bit;
            rdata_out[`TXHW_HW_SZ_HI:`TXHW_HW_SZ_LO] <= alloc;
            rdata_out[`TXHW_HW_CLK_HI:`TXHW_HW_CLK_LO] <= clk_src;
         end
      end
   end
endmodule
`default_nettype wire

/* File: dv/txhw_regs_sva.sv */
// Purpose: concurrent checks on the configuration register block
// Assumes: one clock, synchronous active high reset
// Notes:   bound from the testbench top
`timescale 1ns/10ps
`default_nettype none
module txhw_regs_sva
   import txhw_pkg::*;
(
   // watched ports
   input wire logic clk_in,
   input wire logic rst_in,
   input wire txhw_req_s req_in,
   input wire logic [1:0] rx_align_code_in,
   input wire logic tx_status_full_in,
   input wire logic tx_status_flush_out,
   input wire logic tx_data_flush_out,
   input wire logic tx_status_full_irq_out,
   input wire logic [3:0] tx_fifo_allocation_out,
   input wire logic [1:0] media_clock_source_out,
   input wire logic media_clock_off_out,
   input wire txhw_part_s partition_out,
   input wire logic [5:0] rx_align_bytes_out
);
   // ----------------------------------------
   // one clock domain
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // write strobe aimed at the transmit register
   logic tx_wr;
   assign tx_wr = req_in.wr && req_in.addr == 8'h70;
   a_status_flush_pulse: assert property (
      tx_wr && req_in.wdata[15] |=> tx_status_flush_out ##1 !tx_status_flush_out)
      else $error("status flush pulse wrong");
   a_data_flush_pulse: assert property (
      tx_wr && req_in.wdata[14] |=> tx_data_flush_out ##1 !tx_data_flush_out)
      else $error("data flush pulse wrong");
   a_full_irq_follows: assert property (
      1'b1 |=> tx_status_full_irq_out == $past(tx_status_full_in))
      else $error("full interrupt does not follow full");
   a_clock_off_map: assert property (
      $stable(media_clock_source_out) [*2]
      |-> media_clock_off_out == (media_clock_source_out == 2'b10))
      else $error("clock disable decode wrong");
   a_alloc_ceiling: assert property (
      tx_fifo_allocation_out <= 4'he)
      else $error("allocation above ceiling");
   a_tx_split: assert property (
      !$past(rst_in) |-> partition_out.tx_status == 15'h0200
      && partition_out.tx_data + 15'h0200 == partition_out.tx_total)
      else $error("transmit split wrong");
   a_rx_remainder: assert property (
      !$past(rst_in) |-> partition_out.tx_total + partition_out.rx_total == 15'h4000)
      else $error("receive remainder wrong");
   a_align_decode: assert property (
      (!$past(rst_in) && $stable(rx_align_code_in)) [*2] |-> rx_align_bytes_out ==
      (rx_align_code_in == 2'b01 ? 6'h10 : rx_align_code_in == 2'b10 ? 6'h20 : 6'h04))
      else $error("alignment decode wrong");
   // main scenarios reached
   c_flush: cover property (tx_status_flush_out && tx_data_flush_out);
   c_full: cover property (tx_status_full_irq_out && tx_status_full_in);
   c_clock_off: cover property (media_clock_off_out);
endmodule
`default_nettype wire

/* File: dv/txhw_host.sv */
// Purpose: host processor model on the register port
// Assumes: one access at a time, strobes one cycle wide
// Notes:   released address and data show their inverse, not stale values
`timescale 1ns/10ps
`default_nettype none
module txhw_host
   import txhw_pkg::*;
(
   // clock
   input wire logic clk_in,
   // register port
   input wire logic [31:0] rdata_in,
   output var txhw_req_s req_out
);
   initial req_out = '0;
   // one write strobe, then release
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      req_out <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clk_in);
      req_out <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // read strobe; data is registered, so take it an edge later
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      req_out <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
      @(posedge clk_in);
      req_out <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 32'hffff_ffff};
      @(posedge clk_in);
      #1;
      d = rdata_in;
   endtask
endmodule
`default_nettype wire

/* File: dv/tx_and_hw_config_regs_test.sv */
// Purpose: self-checking bench for the configuration register block
// Assumes: host model drives the register port
// Notes:   one task per scenario
`timescale 1ns/10ps
`default_nettype none
module tx_and_hw_config_regs_test;
   import txhw_pkg::*;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   txhw_req_s req;
   logic [31:0] rdata;
   logic [1:0] align_code = 2'b00;
   logic busy = 1'b0, full = 1'b0, strap = 1'b0;
   logic run, on, sflush, dflush, irq, must_be_one_bit, clk_off;
   logic [3:0] alloc;
   logic [1:0] clk_src, clk_sel;
   txhw_part_s part;
   logic [5:0] align_bytes;
   int errors = 0;
   int total_checks = 0;
   // 40 MHz clock
   always #12.5 clk_in = ~clk_in;
   txhw_host host (.clk_in(clk_in), .rdata_in(rdata), .req_out(req));
   txhw_regs dut (.clk_in(clk_in), .rst_in(rst_in), .req_in(req), .rdata_out(rdata),
      .rx_align_code_in(align_code), .tx_frame_busy_in(busy), .tx_status_full_in(full),
      .auto_crossover_strap_in(strap), .tx_run_out(run), .tx_on_out(on),
      .tx_status_flush_out(sflush), .tx_data_flush_out(dflush),
      .tx_status_full_irq_out(irq), .must_be_one_bit_out(must_be_one_bit),
      .tx_fifo_allocation_out(alloc), .media_clock_source_out(clk_src),
      .media_clock_sel_out(clk_sel), .media_clock_off_out(clk_off),
      .partition_out(part), .rx_align_bytes_out(align_bytes));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      logic [31:0] d;
      host.rd(8'h70, d);
      chk(d, 32'h0);
      host.rd(8'h74, d);
      chk(d, 32'h0005_0000);
      $display("test reset values done");
   endtask
   task automatic t_hwcfg;
      logic [31:0] d;
      @(posedge clk_in) strap <= 1'b1;
      // transmitter still off here, so the write is legal
      host.wr(8'h74, 32'hffff_ffff);
      wait_cyc(3);
      host.rd(8'h74, d);
      chk(d, 32'h011e_0060);
      for (int c = 0; c < 4; c++) begin
         host.wr(8'h74, 32'h0012_0000 | (c << 5));
         wait_cyc(2);
         chk({30'h0, clk_sel}, (c == 1) ? 32'h1 : 32'h0);
         chk({31'h0, clk_off}, (c == 2) ? 32'h1 : 32'h0);
         chk({30'h0, clk_src}, c);
         chk({27'h0, must_be_one_bit, alloc}, 32'h12);
      end
      chk({17'h0, part.tx_data}, 32'h600);
      chk({17'h0, part.rx_total}, 32'h3800);
      $display("test hardware config done");
   endtask
   task automatic t_align;
      for (int c = 0; c < 4; c++) begin
         @(posedge clk_in) align_code <= 2'(c);
         wait_cyc(3);
         chk({26'h0, align_bytes}, (c == 1) ? 32'h10 : (c == 2) ? 32'h20 : 32'h4);
      end
      $display("test alignment done");
   endtask
   task automatic t_flush;
      logic [31:0] d;
      host.wr(8'h70, 32'h0000_c000);
      #1;
      chk({30'h0, sflush, dflush}, 32'h3);
      wait_cyc(1);
      chk({30'h0, sflush, dflush}, 32'h0);
      host.rd(8'h70, d);
      chk(d, 32'h0);
      host.wr(8'h70, 32'hffff_3ff8);
      host.rd(8'h70, d);
      chk(d, 32'h0);
      $display("test flush done");
   endtask
   task automatic t_run;
      host.wr(8'h70, 32'h2);
      wait_cyc(2);
      chk({30'h0, on, run}, 32'h3);
      @(posedge clk_in) full <= 1'b1;
      wait_cyc(3);
      chk({30'h0, irq, run}, 32'h2);
      host.wr(8'h70, 32'h6);
      wait_cyc(3);
      chk({30'h0, irq, run}, 32'h3);
      @(posedge clk_in) full <= 1'b0;
      $display("test run and overrun done");
   endtask
   task automatic t_stop;
      logic [31:0] d;
      @(posedge clk_in) busy <= 1'b1;
      host.wr(8'h70, 32'h3);
      wait_cyc(3);
      chk({31'h0, run}, 32'h1);
      host.wr(8'h70, 32'h2);
      host.rd(8'h70, d);
      chk(d, 32'h3);
      @(posedge clk_in) busy <= 1'b0;
      wait_cyc(3);
      host.rd(8'h70, d);
      chk(d, 32'h0);
      chk({30'h0, on, run}, 32'h0);
      $display("test stop done");
   endtask
   // ----------------------------------------
   // sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      t_reset;
      t_hwcfg;
      t_align;
      t_flush;
      t_run;
      t_stop;
      print_verdict;
   end
   // the tests need about 110 cycles; this is far beyond
   initial begin
      #100_000;
      errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      print_verdict;
   end
endmodule
bind txhw_regs txhw_regs_sva u_sva (.clk_in(clk_in), .rst_in(rst_in), .req_in(req_in),
   .rx_align_code_in(rx_align_code_in), .tx_status_full_in(tx_status_full_in),
   .tx_status_flush_out(tx_status_flush_out), .tx_data_flush_out(tx_data_flush_out),
   .tx_status_full_irq_out(tx_status_full_irq_out),
   .tx_fifo_allocation_out(tx_fifo_allocation_out),
   .media_clock_source_out(media_clock_source_out),
   .media_clock_off_out(media_clock_off_out), .partition_out(partition_out),
   .rx_align_bytes_out(rx_align_bytes_out));
`default_nettype wire
